// ### bench/hrio_channel_assertions.sv
// Port checker for the cycle-steal channel sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hrio_defs.svh"
module hrio_channel_assertions (
  input wire logic                 sys_clk_i,
  input wire logic                 reset_n_i,
  input wire logic [`HRIO_NCH-1:0] std_int_o,
  input wire logic                 set_fast_flags_instr_i,
  input wire logic                 clear_fast_flags_instr_i,
  input wire logic [`HRIO_NCH-1:0] fast_flag_mask_i,
  input wire logic [`HRIO_NCH-1:0] fast_flags_o,
  input wire logic                 cpu_reg_rd_i,
  input wire logic                 cpu_reg_rvalid_o,
  input wire logic                 steal_o,
  input wire logic                 mem_req_o,
  input wire logic [5:0]           dev_addr_o,
  input wire logic [2:0]           io_func_o,
  input wire logic                 io_strobe_o,
  input wire logic                 echo_pulse_i,
  input wire logic                 db_oe_o,
  input wire logic                 io_timeout_o,
  input wire logic                 count_ovf_o
);
  // ========
  // Strobe length, too long for a repetition count
  logic [6:0] strb_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !io_strobe_o) strb_cnt <= 7'h00;
    else strb_cnt <= strb_cnt + 7'h01;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ========
  // Properties
  a_strobe_in_steal: assert property (io_strobe_o |-> steal_o &&
    dev_addr_o inside {[6'h10:6'h16]}) else $error("strobe outside steal");
  a_oe_output_only: assert property (db_oe_o |-> io_strobe_o &&
    io_func_o == 3'h2) else $error("bus driven outside word out");
  a_timeout_bound: assert property (strb_cnt <= 7'h2B)
    else $error("strobe outlived timeout");
  a_timeout_cause: assert property (io_timeout_o |->
    $past(strb_cnt, 2) >= 7'h25) else $error("early timeout");
  a_echo_drops: assert property ($rose(echo_pulse_i) && io_strobe_o
    |-> ##[1:5] !io_strobe_o) else $error("strobe kept after echo");
  a_reg_refused: assert property (cpu_reg_rd_i && steal_o |=>
    !cpu_reg_rvalid_o) else $error("read answered during steal");
  a_flag_set: assert property (set_fast_flags_instr_i |=>
    (fast_flags_o & $past(fast_flag_mask_i)) == $past(fast_flag_mask_i))
    else $error("flag not set");
  a_flag_clear: assert property (clear_fast_flags_instr_i &&
    !set_fast_flags_instr_i |=> (fast_flags_o & $past(fast_flag_mask_i))
    == 7'h00) else $error("flag not cleared");
  a_flag_no_self: assert property (!set_fast_flags_instr_i |=>
    (fast_flags_o & ~$past(fast_flags_o)) == 7'h00)
    else $error("flag set without instruction");
  a_ovf_int: assert property (count_ovf_o && !steal_o |->
    std_int_o != 7'h00) else $error("no completion interrupt");
  a_req_in_steal: assert property (mem_req_o |-> steal_o)
    else $error("memory cycle outside steal");
  cover property ($rose(io_strobe_o) && io_func_o == 3'h1);
  cover property (db_oe_o);
  cover property ($rose(io_timeout_o));
  cover property ($rose(count_ovf_o));
endmodule : hrio_channel_assertions

bind hrio_channel hrio_channel_assertions hrio_channel_assertions_inst (
  .sys_clk_i, .reset_n_i, .std_int_o, .set_fast_flags_instr_i,
  .clear_fast_flags_instr_i, .fast_flag_mask_i, .fast_flags_o,
  .cpu_reg_rd_i, .cpu_reg_rvalid_o, .steal_o, .mem_req_o, .dev_addr_o,
  .io_func_o, .io_strobe_o, .echo_pulse_i, .db_oe_o, .io_timeout_o,
  .count_ovf_o
);
`default_nettype wire

// ### bench/hrio_ctrl_model.sv
// Behavioural peripheral controller on the parallel I/O bus
`timescale 1ns/1ps
`default_nettype none
module hrio_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [2:0]  chan_i,
  input  wire logic        go_i,
  input  wire logic [15:0] n_i,
  input  wire logic        slow_i,
  input  wire logic        mute_i,
  input  wire logic [15:0] data_i,
  input  wire logic [5:0]  dev_addr_i,
  input  wire logic [2:0]  func_i,
  input  wire logic        strobe_i,
  input  wire logic [15:0] bus_i,
  output logic      [6:0]  int_o,
  output logic             echo_o,
  output logic      [15:0] db_o,
  output logic             db_oe_o,
  output logic      [15:0] rx_data_o,
  output logic             rx_stb_o
);
  int   rem = 0;
  int   t = 0;
  logic sel;
  logic eor = 1'b0;
  initial {echo_o, db_oe_o, rx_stb_o} = 3'h0;
  assign sel = strobe_i && dev_addr_i == 6'h10 + {3'h0, chan_i};
  // Interrupt drops once strobed, rises again for the next item;
  // end of record raises a program interrupt on spare line 4
  assign int_o = ((rem != 0 && t == 0) ? 7'h01 << chan_i : 7'h00) |
                 (eor ? 7'h10 : 7'h00);
  // Rising edge, so bench stimulus set on the falling edge never races
  always @(posedge clk_i) begin
    rx_stb_o <= 1'b0;
    if (!reset_n_i) begin
      rem <= 0;
      eor <= 1'b0;
      t <= 0;
      echo_o <= 1'b0;
      db_oe_o <= 1'b0;
    end else if (go_i) begin
      rem <= n_i;
      eor <= 1'b0;
    end else if (t < 0) begin
      if (!strobe_i) t <= 0;
    end else if (t == 0 && sel) begin
      rem <= rem - 1;
      if (rem == 1) eor <= 1'b1;
      t <= mute_i ? -1 : 1;
      db_oe_o <= !mute_i && func_i == 3'h1;
      db_o <= data_i;
    end else if (t > 0) begin
      t <= t + 1;
      if (t == (slow_i ? 20 : 1)) begin
        echo_o <= 1'b1;
        rx_data_o <= bus_i;
        rx_stb_o <= func_i == 3'h2;
      end
      if (t == (slow_i ? 22 : 3)) begin
        echo_o <= 1'b0;
        db_oe_o <= 1'b0;
        t <= -1;
      end
    end
  end
endmodule : hrio_ctrl_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the cycle-steal channel sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic [6:0]  hr_int, int_ack, std_int, mask, flags;
  logic        clk, reset_n, set_f, clr_f, rd, wr, rvalid, steal, mreq, mwe;
  logic        mdone, strobe, echo, oe, to, ovf, p_oe, go, slow, mute, rx_stb;
  logic        saw_to, ovf_d;
  logic [3:0]  raddr;
  logic [15:0] wdata, rdata, maddr, mwdata, mrdata, db, dbo, p_db, rx, n;
  logic [15:0] lastw, pdata, exp_out, rw;
  logic [15:0] mem [64];
  logic [15:0] regv [16];
  logic [1:0]  be;
  logic [5:0]  dev;
  logic [2:0]  func, ch;
  int          n_fail, check_count, seed, m_addr, m_cnt, m_mode, m_dir, d_cnt;

  hrio_channel hrio_channel_inst (
    .sys_clk_i(clk), .reset_n_i(reset_n), .hr_int_i(hr_int),
    .int_ack_i(int_ack), .std_int_o(std_int),
    .set_fast_flags_instr_i(set_f), .clear_fast_flags_instr_i(clr_f),
    .fast_flag_mask_i(mask), .fast_flags_o(flags), .cpu_reg_rd_i(rd),
    .cpu_reg_wr_i(wr), .cpu_reg_addr_i(raddr), .cpu_reg_wdata_i(wdata),
    .cpu_reg_rdata_o(rdata), .cpu_reg_rvalid_o(rvalid), .steal_o(steal),
    .mem_addr_o(maddr), .mem_req_o(mreq), .mem_we_o(mwe), .mem_be_o(be),
    .mem_wdata_o(mwdata), .mem_rdata_i(mrdata), .mem_done_i(mdone),
    .dev_addr_o(dev), .io_func_o(func), .io_strobe_o(strobe),
    .echo_pulse_i(echo), .db_i(db), .db_o(dbo), .db_oe_o(oe),
    .io_timeout_o(to), .count_ovf_o(ovf));
  hrio_ctrl_model hrio_ctrl_model_inst (
    .clk_i(clk), .reset_n_i(reset_n), .chan_i(ch), .go_i(go), .n_i(n),
    .slow_i(slow), .mute_i(mute), .data_i(pdata), .dev_addr_i(dev),
    .func_i(func), .strobe_i(strobe), .bus_i(db), .int_o(hr_int),
    .echo_o(echo), .db_o(p_db), .db_oe_o(p_oe), .rx_data_o(rx),
    .rx_stb_o(rx_stb));

  // Undriven bus toggles, so a stale value never passes for data
  assign db = (oe === 1'b1) ? dbo : (p_oe === 1'b1) ? p_db : ~lastw;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic hang;
    cmp(16'h0001, 16'h0000);
    tally_and_finish();
  endtask : hang
  task automatic wait_idle;
    int i;
    for (i = 0; i < 100 && steal !== 1'b0; i++) tick(1);
    if (steal !== 1'b0) hang();
  endtask : wait_idle
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    wait_idle();
    wr = 1'b1; raddr = a; wdata = d; tick(1); wr = 1'b0; tick(1);
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    int i;
    wait_idle();
    rd = 1'b1; raddr = a; tick(1); rd = 1'b0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) tick(1);
    cmp(16'h0001, {15'h0, rvalid});
    d = rdata;
    tick(1);
  endtask : reg_rd
  task automatic flag_op(input logic s, input logic c, input logic [6:0] m);
    set_f = s; clr_f = c; mask = m; tick(1); set_f = 1'b0; clr_f = 1'b0;
    tick(1);
  endtask : flag_op
  task automatic run(input int c, input int dir, input int md, input int a,
                     input int cnt, input int sl, input int mu);
    logic [15:0] v;
    int          i;
    bit          tried;
    tried = 0;
    reg_wr(4'(2 + 2 * c), 16'(a));
    reg_wr(4'(3 + 2 * c), {dir[0], md[0], 14'(16384 - cnt)});
    flag_op(1'b1, 1'b0, 7'(1 << c));
    m_addr = a & 32'hFFFF; m_cnt = 0; m_mode = md; m_dir = dir; saw_to = 1'b0;
    mute = mu[0]; slow = sl[0]; ch = 3'(c); n = 16'(cnt);
    go = 1'b1; tick(1); go = 1'b0;
    for (i = 0; i < 4000 && std_int[c] !== 1'b1; i++) begin
      if (steal === 1'b1 && !tried) begin
        rd = 1'b1; tick(1); rd = 1'b0; tried = 1;
      end
      tick(1);
    end
    if (i == 4000) hang();
    cmp(16'h0001, {15'h0, std_int[4]});
    cmp(16'(cnt), 16'(m_cnt));
    cmp(16'h0000, {15'h0, flags[c]});
    cmp(16'(mu), {15'h0, saw_to});
    reg_rd(4'(2 + 2 * c), v);
    cmp(16'(a + cnt), v);
    reg_rd(4'(3 + 2 * c), v);
    cmp({dir[0], md[0], 14'h0}, v);
    int_ack = 7'(1 << c); tick(1); int_ack = 7'h00; tick(1);
    cmp(16'h0000, {15'h0, std_int[c]});
    $display("test ch=%0d dir=%0d mode=%0d done", c, dir, md);
  endtask : run

  // ========
  // Memory and bus model
  always @(negedge clk) begin
    lastw <= db;
    mdone <= 1'b0;
    ovf_d <= ovf;
    if (to === 1'b1) saw_to <= 1'b1;
    // Overflow rises while the last item is still in flight
    if (ovf === 1'b1 && ovf_d !== 1'b1)
      cmp(n - 16'h0001, 16'(m_cnt));
    if (d_cnt == 1) mdone <= 1'b1;
    if (d_cnt > 0) d_cnt <= d_cnt - 1;
    if (mreq === 1'b1) begin
      rw = m_mode ? 16'(m_addr) : 16'(m_addr >> 1);
      cmp(rw, maddr);
      cmp(16'(m_dir), {15'h0, mwe});
      if (m_dir) begin
        cmp(m_mode ? 16'h3 : (m_addr % 2 ? 16'h1 : 16'h2), {14'h0, be});
        if (!mute) cmp(m_mode ? pdata : {2{pdata[7:0]}}, mwdata);
        pdata = $random(seed);
      end else begin
        rw = mem[rw[5:0]];
        mrdata <= rw;
        exp_out = m_mode ? rw : {(m_addr % 2 ? rw[7:0] : rw[15:8]), 8'h00};
      end
      m_addr = (m_addr + 1) & 32'hFFFF;
      m_cnt++;
      d_cnt <= 2;
    end
    if (rx_stb === 1'b1) cmp(exp_out, rx);
  end

  initial begin
    int          i;
    logic [15:0] v;
    seed = 50141; n_fail = 0; check_count = 0; d_cnt = 0; lastw = 16'h0000;
    {reset_n, set_f, clr_f, rd, wr, go, slow, mute, mdone} = 9'h000;
    int_ack = 7'h00; mask = 7'h00; raddr = 4'h0; wdata = 16'h0000;
    mrdata = 16'h0000; ch = 3'h0; n = 16'h0000; m_mode = 0; m_dir = 0;
    for (i = 0; i < 64; i++) mem[i] = $random(seed);
    pdata = $random(seed);
    tick(6);
    reset_n = 1'b1;
    cmp(16'h0000, {9'h0, flags});
    cmp(16'h0000, {9'h0, std_int});
    for (i = 2; i < 16; i++) begin
      regv[i] = $random(seed);
      reg_wr(4'(i), regv[i]);
    end
    for (i = 2; i < 16; i++) begin
      reg_rd(4'(i), v);
      cmp(regv[i], v);
    end
    $display("test registers done");
    flag_op(1'b1, 1'b0, 7'h55); cmp(16'h0055, {9'h0, flags});
    flag_op(1'b0, 1'b1, 7'h05); cmp(16'h0050, {9'h0, flags});
    flag_op(1'b1, 1'b1, 7'h0A); cmp(16'h005A, {9'h0, flags});
    flag_op(1'b0, 1'b1, 7'h7F); cmp(16'h0000, {9'h0, flags});
    ch = 3'h2; n = 16'h0001; go = 1'b1; tick(1); go = 1'b0; tick(6);
    cmp(16'h0001, {15'h0, std_int[2]});
    cmp(16'h0000, {15'h0, steal});
    n = 16'h0000; go = 1'b1; tick(1); go = 1'b0; tick(4);
    cmp(16'h0000, {15'h0, std_int[2]});
    $display("test flags done");
    run(0, 1, 1, $random(seed), 3, 0, 0);
    run(3, 1, 0, 16'hFFFF, 4, 1, 0);
    run(6, 0, 0, $random(seed), 3, 0, 0);
    run(5, 0, 1, $random(seed), 2, 1, 0);
    run(1, 1, 1, $random(seed), 1, 0, 1);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

// ### core/hrio_channel.sv
// High rate cycle-steal block transfer sequencer with seven channels
`timescale 1ns/1ps
`default_nettype none
`include "hrio_defs.svh"

module hrio_channel (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic [`HRIO_NCH-1:0]     hr_int_i,
  input  wire logic [`HRIO_NCH-1:0]     int_ack_i,
  output logic      [`HRIO_NCH-1:0]     std_int_o,
  input  wire logic                     set_fast_flags_instr_i,
  input  wire logic                     clear_fast_flags_instr_i,
  input  wire logic [`HRIO_NCH-1:0]     fast_flag_mask_i,
  output logic      [`HRIO_NCH-1:0]     fast_flags_o,
  input  wire logic                     cpu_reg_rd_i,
  input  wire logic                     cpu_reg_wr_i,
  input  wire logic [`HRIO_REG_W-1:0]   cpu_reg_addr_i,
  input  wire logic [15:0]              cpu_reg_wdata_i,
  output logic      [15:0]              cpu_reg_rdata_o,
  output logic                          cpu_reg_rvalid_o,
  output logic                          steal_o,
  output logic      [15:0]              mem_addr_o,
  output logic                          mem_req_o,
  output logic                          mem_we_o,
  output logic      [1:0]               mem_be_o,
  output logic      [15:0]              mem_wdata_o,
  input  wire logic [15:0]              mem_rdata_i,
  input  wire logic                     mem_done_i,
  output logic      [`HRIO_DEV_W-1:0]   dev_addr_o,
  output logic      [`HRIO_FUNC_W-1:0]  io_func_o,
  output logic                          io_strobe_o,
  input  wire logic                     echo_pulse_i,
  input  wire logic [15:0]              db_i,
  output logic      [15:0]              db_o,
  output logic                          db_oe_o,
  output logic                          io_timeout_o,
  output logic                          count_ovf_o
);

  // ========================================================
  // Helpers
  // Even register of a channel: X2, X4 ... X14
  function automatic logic [`HRIO_REG_W-1:0] even_reg(
    input logic [`HRIO_CH_W-1:0] ch
  );
    even_reg = `HRIO_FIRST_REG + {ch, 1'b0};
  endfunction : even_reg

  // Interrupt 0 has the highest priority
  function automatic logic [`HRIO_CH_W-1:0] first_set(
    input logic [`HRIO_NCH-1:0] v
  );
    first_set = '0;
    for (int i = `HRIO_NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = i[`HRIO_CH_W-1:0];
      end
    end
  endfunction : first_set

  function automatic logic [`HRIO_NCH-1:0] ch_bit(
    input logic [`HRIO_CH_W-1:0] ch
  );
    ch_bit = `HRIO_NCH'(1) << ch;
  endfunction : ch_bit

  // ========================================================
  // State
  hrio_pkg::hrio_core_t r_reg;
  hrio_pkg::hrio_core_t r_next;
  hrio_rf_if            rf ();

  logic [`HRIO_CNT_W:0]   cnt_sum;
  logic [`HRIO_NCH-1:0]   pending;
  logic                   cpu_ok;
  logic                   core_rd;
  logic [`HRIO_REG_W-1:0] core_rd_addr;
  logic [7:0]             out_byte;

  hrio_regfile u_regfile (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .rf        (rf)
  );

  // ========================================================
  // Next state
  always_comb begin
    r_next         = r_reg;
    core_rd        = 1'b0;
    core_rd_addr   = even_reg(r_reg.chan);
    rf.wr_en       = 1'b0;
    rf.wr_addr     = even_reg(r_reg.chan);
    rf.wr_data     = r_reg.d;
    cnt_sum        = {1'b0, rf.rd_data[`HRIO_CNT_MSB:0]} + 1'b1;
    pending        = r_reg.int_s2 & r_reg.flags;
    out_byte       = r_reg.h[0] ? r_reg.m[`HRIO_LO_LANE]
                                : r_reg.m[`HRIO_HI_LANE];
    cpu_ok         = (r_reg.state == hrio_pkg::S_IDLE) ||
                     (r_reg.state == hrio_pkg::S_GAP);

    // Pins pass two flops before any use
    r_next.int_s1  = hr_int_i;
    r_next.int_s2  = r_reg.int_s1;
    r_next.echo_s1 = echo_pulse_i;
    r_next.echo_s2 = r_reg.echo_s1;
    r_next.db_s1   = db_i;
    r_next.db_s2   = r_reg.db_s1;

    r_next.mem_req = 1'b0;
    r_next.timeout = 1'b0;
    r_next.rvalid  = cpu_ok && cpu_reg_rd_i;
    r_next.done_int = r_reg.done_int & ~int_ack_i;
    if (clear_fast_flags_instr_i) begin
      r_next.flags = r_reg.flags & ~fast_flag_mask_i;
    end
    if (mem_done_i) begin
      r_next.mem_ok = 1'b1;
      if (!r_reg.mem_we) begin
        r_next.m = mem_rdata_i;
      end
    end

    // Echo ends the bus operation; timer bounds the wait
    if (r_reg.strobe) begin
      r_next.timer = r_reg.timer + 1'b1;
      if (r_reg.echo_s2) begin
        r_next.strobe = 1'b0;
        r_next.func   = `HRIO_FUNC_NONE;
        if (r_reg.dir == `HRIO_DIR_IN) begin
          if (r_reg.mode == `HRIO_MODE_WORD) begin
            r_next.m = r_reg.db_s2;
          end else begin
            r_next.m = {2{r_reg.db_s2[`HRIO_LO_LANE]}};
          end
        end
      end else if (r_reg.timer == `HRIO_TMR_W'(`HRIO_TO_CYC - 1)) begin
        r_next.strobe  = 1'b0;
        r_next.func    = `HRIO_FUNC_NONE;
        r_next.timeout = 1'b1;
        if (r_reg.dir == `HRIO_DIR_IN) begin
          r_next.m = r_reg.db_s2;
        end
      end
    end

    unique case (r_reg.state)
      hrio_pkg::S_IDLE: begin
        if (|pending) begin
          r_next.chan     = first_set(pending);
          r_next.dev_addr = `HRIO_DEV_BASE +
                            {{(`HRIO_DEV_W-`HRIO_CH_W){1'b0}},
                             first_set(pending)};
          r_next.state    = hrio_pkg::S_RD_EVEN;
        end
      end
      hrio_pkg::S_RD_EVEN: begin
        core_rd      = 1'b1;
        core_rd_addr = even_reg(r_reg.chan);
        r_next.state = hrio_pkg::S_RD_ODD;
      end
      hrio_pkg::S_RD_ODD: begin
        r_next.d     = rf.rd_data;
        r_next.h     = rf.rd_data;
        core_rd      = 1'b1;
        core_rd_addr = even_reg(r_reg.chan) + 1'b1;
        r_next.state = hrio_pkg::S_CTRL;
      end
      hrio_pkg::S_CTRL: begin
        r_next.dir   = rf.rd_data[`HRIO_DIR_BIT];
        r_next.mode  = rf.rd_data[`HRIO_MODE_BIT];
        r_next.d     = {rf.rd_data[15:`HRIO_CNT_MSB+1],
                        cnt_sum[`HRIO_CNT_MSB:0]};
        r_next.ovf   = cnt_sum[`HRIO_CNT_W];
        if (rf.rd_data[`HRIO_MODE_BIT] == `HRIO_MODE_WORD) begin
          r_next.mem_addr = r_reg.h;
          r_next.mem_be   = `HRIO_BE_WORD;
        end else begin
          r_next.mem_addr = {1'b0, r_reg.h[15:1]};
          r_next.mem_be   = r_reg.h[0] ? `HRIO_BE_LO
                                       : `HRIO_BE_HI;
        end
        r_next.timer = '0;
        r_next.sent  = 1'b0;
        if (rf.rd_data[`HRIO_DIR_BIT] == `HRIO_DIR_IN) begin
          r_next.strobe = 1'b1;
          r_next.func   = `HRIO_FUNC_WTI;
          r_next.sent   = 1'b1;
        end else begin
          r_next.mem_req = 1'b1;
          r_next.mem_we  = 1'b0;
          r_next.mem_ok  = 1'b0;
        end
        r_next.state = hrio_pkg::S_WB_ODD;
      end
      hrio_pkg::S_WB_ODD: begin
        rf.wr_en     = 1'b1;
        rf.wr_addr   = even_reg(r_reg.chan) + 1'b1;
        rf.wr_data   = r_reg.d;
        r_next.d     = r_reg.h + 16'h0001;
        r_next.state = hrio_pkg::S_WB_EVEN;
      end
      hrio_pkg::S_WB_EVEN: begin
        rf.wr_en     = 1'b1;
        rf.wr_addr   = even_reg(r_reg.chan);
        rf.wr_data   = r_reg.d;
        r_next.state = hrio_pkg::S_XFER;
      end
      hrio_pkg::S_XFER: begin
        if (r_reg.dir == `HRIO_DIR_IN) begin
          if (!r_reg.strobe) begin
            r_next.mem_req = 1'b1;
            r_next.mem_we  = 1'b1;
            r_next.mem_ok  = 1'b0;
            r_next.state   = hrio_pkg::S_MEM_WR;
          end
        end else if (!r_reg.sent) begin
          if (r_reg.mem_ok) begin
            if (r_reg.mode == `HRIO_MODE_WORD) begin
              r_next.db_out = r_reg.m;
            end else begin
              r_next.db_out = {out_byte, `HRIO_BYTE_ZERO};
            end
            r_next.strobe = 1'b1;
            r_next.func   = `HRIO_FUNC_WTO;
            r_next.sent   = 1'b1;
            r_next.timer  = '0;
          end
        end else if (!r_reg.strobe) begin
          r_next.state = hrio_pkg::S_FIN;
        end
      end
      hrio_pkg::S_MEM_WR: begin
        if (r_reg.mem_ok) begin
          r_next.mem_we = 1'b0;
          r_next.state  = hrio_pkg::S_FIN;
        end
      end
      hrio_pkg::S_FIN: begin
        if (r_reg.ovf) begin
          r_next.flags    = r_next.flags & ~ch_bit(r_reg.chan);
          r_next.done_int = r_next.done_int | ch_bit(r_reg.chan);
        end
        r_next.timer = '0;
        r_next.state = hrio_pkg::S_GAP;
      end
      hrio_pkg::S_GAP: begin
        // Lets the controller's reset interrupt reach the synchroniser
        r_next.timer = r_reg.timer + 1'b1;
        r_next.ovf   = 1'b0;
        if (r_reg.timer == `HRIO_TMR_W'(`HRIO_GAP_CYC - 1)) begin
          r_next.state = hrio_pkg::S_IDLE;
        end
      end
      default: begin
        r_next.state = hrio_pkg::S_IDLE;
      end
    endcase

    if (set_fast_flags_instr_i) begin
      r_next.flags = r_next.flags | fast_flag_mask_i;
    end

    // Software access only while no cycle is being stolen
    if (cpu_ok && cpu_reg_wr_i) begin
      rf.wr_en   = 1'b1;
      rf.wr_addr = cpu_reg_addr_i;
      rf.wr_data = cpu_reg_wdata_i;
    end
  end

  assign rf.rd_en   = core_rd || (cpu_ok && cpu_reg_rd_i);
  assign rf.rd_addr = core_rd ? core_rd_addr : cpu_reg_addr_i;

  // ========================================================
  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      r_reg       <= '0;
      r_reg.state <= hrio_pkg::S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ========================================================
  // Outputs
  // Unflagged positions go to the normal interrupt sequence
  assign std_int_o        = (r_reg.int_s2 & ~r_reg.flags) |
                            r_reg.done_int;
  assign fast_flags_o     = r_reg.flags;
  assign cpu_reg_rdata_o  = rf.rd_data;
  assign cpu_reg_rvalid_o = r_reg.rvalid;
  assign steal_o          = !cpu_ok;
  assign mem_addr_o       = r_reg.mem_addr;
  assign mem_req_o        = r_reg.mem_req;
  assign mem_we_o         = r_reg.mem_we;
  assign mem_be_o         = r_reg.mem_be;
  assign mem_wdata_o      = r_reg.m;
  assign dev_addr_o       = r_reg.dev_addr;
  assign io_func_o        = r_reg.func;
  assign io_strobe_o      = r_reg.strobe;
  assign db_o             = r_reg.db_out;
  assign db_oe_o          = r_reg.strobe && (r_reg.dir != `HRIO_DIR_IN);
  assign io_timeout_o     = r_reg.timeout;
  assign count_ovf_o      = r_reg.ovf;

endmodule : hrio_channel

`default_nettype wire

// ### core/hrio_defs.svh
// Constants of the high rate cycle-steal channel sequencer
`ifndef HRIO_DEFS_SVH
`define HRIO_DEFS_SVH

// ==========================================================
// Channels and general registers
`define HRIO_NCH        7
`define HRIO_CH_W       3
`define HRIO_REG_W      4
`define HRIO_FIRST_REG  4'h2
`define HRIO_NREGS      16

// ==========================================================
// Control word layout (odd register), bit 15 is the MSB
`define HRIO_DIR_BIT    15
`define HRIO_MODE_BIT   14
`define HRIO_CNT_MSB    13
`define HRIO_CNT_W      14
`define HRIO_DIR_IN     1'b1
`define HRIO_MODE_WORD  1'b1

// ==========================================================
// Byte lanes: line 00 is vector bit 15
`define HRIO_HI_LANE    15:8
`define HRIO_LO_LANE    7:0
`define HRIO_BE_HI      2'h2
`define HRIO_BE_LO      2'h1
`define HRIO_BE_WORD    2'h3
`define HRIO_BYTE_ZERO  8'h00

// ==========================================================
// Bus codes
`define HRIO_DEV_W      6
`define HRIO_DEV_BASE   6'h10
`define HRIO_FUNC_W     3
`define HRIO_FUNC_NONE  3'h0
`define HRIO_FUNC_WTI   3'h1
`define HRIO_FUNC_WTO   3'h2

// ==========================================================
// Timing
`define HRIO_CLK_NS     50
`define HRIO_TO_NS      2000
`define HRIO_TO_CYC     ((`HRIO_TO_NS) / (`HRIO_CLK_NS))
`define HRIO_GAP_CYC    3
`define HRIO_TMR_W      6

`endif

// ### core/hrio_pkg.sv
// Types of the high rate cycle-steal channel sequencer
`include "hrio_defs.svh"

package hrio_pkg;

  // ========================================================
  // Sequencer states
  typedef enum logic [9:0] {
    S_IDLE    = 10'h001,
    S_RD_EVEN = 10'h002,
    S_RD_ODD  = 10'h004,
    S_CTRL    = 10'h008,
    S_WB_ODD  = 10'h010,
    S_WB_EVEN = 10'h020,
    S_XFER    = 10'h040,
    S_MEM_WR  = 10'h080,
    S_FIN     = 10'h100,
    S_GAP     = 10'h200
  } hrio_state_t;

  // ========================================================
  // Whole state of the sequencer
  typedef struct packed {
    hrio_state_t                state;
    logic [`HRIO_CH_W-1:0]      chan;
    logic [`HRIO_NCH-1:0]       flags;
    logic [`HRIO_NCH-1:0]       done_int;
    logic [15:0]                d;
    logic [15:0]                h;
    logic [15:0]                m;
    logic [15:0]                db_out;
    logic [15:0]                mem_addr;
    logic [1:0]                 mem_be;
    logic                       dir;
    logic                       mode;
    logic                       ovf;
    logic                       mem_ok;
    logic                       mem_req;
    logic                       mem_we;
    logic                       strobe;
    logic                       sent;
    logic                       timeout;
    logic [`HRIO_TMR_W-1:0]     timer;
    logic [`HRIO_DEV_W-1:0]     dev_addr;
    logic [`HRIO_FUNC_W-1:0]    func;
    logic                       rvalid;
    logic [`HRIO_NCH-1:0]       int_s1;
    logic [`HRIO_NCH-1:0]       int_s2;
    logic                       echo_s1;
    logic                       echo_s2;
    logic [15:0]                db_s1;
    logic [15:0]                db_s2;
  } hrio_core_t;

endpackage : hrio_pkg

// ### core/hrio_regfile.sv
// General register store, one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
`include "hrio_defs.svh"

module hrio_regfile (
  input  wire logic   sys_clk_i,
  input  wire logic   reset_n_i,
  hrio_rf_if.store    rf
);

  logic [15:0] regs_reg [0:`HRIO_NREGS-1];
  logic [15:0] rd_reg;

  // ========================================================
  // Storage; contents are undefined until software loads them
  always_ff @(posedge sys_clk_i) begin
    if (rf.wr_en) begin
      regs_reg[rf.wr_addr] <= rf.wr_data;
    end
  end

  // ========================================================
  // Read data from a register, one cycle after the request
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rd_reg <= 16'h0000;
    end else if (rf.rd_en) begin
      rd_reg <= regs_reg[rf.rd_addr];
    end
  end

  assign rf.rd_data = rd_reg;

endmodule : hrio_regfile

`default_nettype wire

// ### core/hrio_rf_if.sv
// Port bundle between the sequencer and the general register store
`timescale 1ns/1ps
`default_nettype none
`include "hrio_defs.svh"

interface hrio_rf_if;
  logic                    rd_en;
  logic [`HRIO_REG_W-1:0]  rd_addr;
  logic [15:0]             rd_data;
  logic                    wr_en;
  logic [`HRIO_REG_W-1:0]  wr_addr;
  logic [15:0]             wr_data;

  modport core  (output rd_en, rd_addr, wr_en, wr_addr, wr_data,
                 input  rd_data);
  modport store (input  rd_en, rd_addr, wr_en, wr_addr, wr_data,
                 output rd_data);
endinterface : hrio_rf_if

`default_nettype wire
